// file: hw/ktd_dialer.sv
// Keypad decoder, tone selector, serial host port and register slave
//
// What this block does
// - One row and column closure starts both tones
// - Two keys sharing a line give one tone
// - Key maps to four-bit code selecting tones
// - Data moves on host shift clocks, and with the keypad between reads
// - Manual mode: keypad code to tones and pin
// - MSB first, one bit per falling edge
// - Manual reads repeat during one key press
// - Six clocks read and reload one code
// - Automatic mode: four clocks write code in
// - Automatic mode ignores the keypad
// - Tone inhibit high suppresses tone output
// - Key valid high only for one key
// - Mute flag high while tones are enabled
// - Converters step a 16-step sine
// - Row tones divided from 500 kHz reference
// - Fractional division gives exact column tones
// - New output bit within 10 us
// - Data pin high at power-up, manual
// - Key valid low by default
//
// The placing of the registers and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/10ps
module ktd_dialer
  import ktd_pkg::*;
#(
  parameter int CLK_HZ = CLK_HZ_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Keypad
  input wire logic [3:0] row_n,
  input wire logic [3:0] col,
  // Host serial port
  input wire logic shift_clock,
  input wire logic transfer_direction,
  input wire logic tone_inhibit,
  input wire logic data_i,
  output logic data_o,
  output logic data_oe,
  output logic single_key_valid,
  output logic tone_active_mute,
  // Converter levels
  output logic [3:0] row_level,
  output logic [3:0] col_level
);
  localparam int REF_DIV = CLK_HZ / REF_HZ; // Clocks per reference tick
  localparam int REF_W = $clog2(REF_DIV);

  initial begin
    if (CLK_HZ % REF_HZ != 0) $error("ktd_dialer: clock not a multiple of reference");
    if (REF_DIV < 2) $error("ktd_dialer: clock too slow");
    if (SYNC_LAT_CYC > T_DV_CYC) $error("ktd_dialer: output too slow");
  end

  // Position of the single set bit of a one-hot nibble
  function automatic logic [1:0] hot_idx(input logic [3:0] v);
    logic [1:0] r;
    r = 2'h0;
    for (int i = 0; i < 4; i++) begin
      if (v[i]) r = 2'(i);
    end
    return r;
  endfunction : hot_idx

  // Row and column of a four-bit key code
  function automatic logic [3:0] code_rc(input logic [3:0] code);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (KEY_CODE[i] == code) r = 4'(i);
    end
    return r;
  endfunction : code_rc

  // ---------------- Pin synchronisers ----------------
  logic [13:0] meta_q; // First stage, read only by the second
  logic [13:0] sync_q; // Second stage
  logic clk_prev_q; // Previous synced shift clock

  // Two flip-flops on every pin input
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= {4'hf, 4'h0, 6'h0};
      sync_q <= {4'hf, 4'h0, 6'h0};
      clk_prev_q <= 1'b0;
    end else begin
      meta_q <= {row_n, col, shift_clock, transfer_direction, tone_inhibit, data_i, 2'h0};
      sync_q <= meta_q;
      clk_prev_q <= sync_q[5]; // Synced shift clock, one cycle late
    end
  end

  logic [3:0] rows; // Active rows
  logic [3:0] cols; // Active columns
  logic sclk;
  logic auto_mode; // Direction high: host writes
  logic inhibit;
  logic sdata;
  logic fall; // Falling edge of shift clock
  assign rows = ~sync_q[13:10];
  assign cols = sync_q[9:6] & 4'hf;
  assign sclk = sync_q[5];
  assign auto_mode = sync_q[4];
  assign inhibit = sync_q[3];
  assign sdata = sync_q[2];
  assign fall = clk_prev_q & ~sclk;

  // ---------------- Keypad decode ----------------
  logic one_row, one_col, any_row, any_col;
  logic single; // Exactly one key down, in manual mode only
  logic [3:0] key_code;
  ktd_tone_sel_t key_sel; // Tones asked by the keypad
  assign one_row = $countones(rows) == 1;
  assign one_col = $countones(cols) == 1;
  assign any_row = |rows;
  assign any_col = |cols;
  assign single = one_row && one_col && !auto_mode;
  assign key_code = KEY_CODE[{hot_idx(rows), hot_idx(cols)}];

  // Row tone needs one row with a closure; likewise the column tone
  always_comb begin
    key_sel.row_en = one_row && any_col;
    key_sel.col_en = one_col && any_row;
    key_sel.row = hot_idx(rows);
    key_sel.col = hot_idx(cols);
  end

  // ---------------- Serial shift register ----------------
  logic [3:0] shreg_q; // Shift register
  logic [2:0] cnt_q; // Edges in the current sequence
  logic mode_q; // Mode seen in the previous cycle
  logic [3:0] auto_code_q; // Code written by the host
  logic auto_valid_q; // A full code has been written

  // Sequence counter; restarts when the direction changes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= CNT_ZERO;
      mode_q <= 1'b0;
    end else begin
      mode_q <= auto_mode;
      if (mode_q != auto_mode) begin
        cnt_q <= CNT_ZERO;
      end else if (fall) begin
        if (auto_mode) begin
          cnt_q <= (cnt_q == WRITE_BITS - 3'h1) ? CNT_ZERO : cnt_q + 3'h1;
        end else begin
          cnt_q <= (cnt_q == READ_LAST) ? CNT_ZERO : cnt_q + 3'h1;
        end
      end
    end
  end

  // Shift register: load, shift out, or shift in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shreg_q <= IDLE_CODE;
    end else if (auto_mode) begin
      if (fall) begin
        shreg_q <= {shreg_q[2:0], sdata};
      end
    end else if (cnt_q == CNT_ZERO && !fall) begin
      shreg_q <= single ? key_code : IDLE_CODE;
    end else if (fall) begin
      shreg_q <= {shreg_q[2:0], 1'b1};
    end
  end

  // Capture a completed host write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      auto_code_q <= IDLE_CODE;
      auto_valid_q <= 1'b0;
    end else if (!auto_mode) begin
      auto_valid_q <= 1'b0;
    end else if (fall) begin
      if (cnt_q == CNT_ZERO) begin
        auto_valid_q <= 1'b0; // New code under way
      end else if (cnt_q == WRITE_BITS - 3'h1) begin
        auto_code_q <= {shreg_q[2:0], sdata};
        auto_valid_q <= 1'b1;
      end
    end
  end

  // Pin drive: output only in manual mode, MSB of the register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_o <= 1'b1;
      data_oe <= 1'b1;
    end else begin
      data_o <= shreg_q[3];
      data_oe <= !auto_mode;
    end
  end

  // ---------------- Registers ----------------
  logic [31:0] ctrl_q; // Control word
  logic tone_en; // Software tone enable
  assign tone_en = ctrl_q[CTRL_TONE_EN];

  // ---------------- Tone selection ----------------
  ktd_tone_sel_t sel; // Tones actually driven
  logic [3:0] auto_rc;
  assign auto_rc = code_rc(auto_code_q);

  // Multiplexer: keypad in manual mode, written code in automatic mode
  always_comb begin
    if (auto_mode) begin
      sel.row_en = auto_valid_q;
      sel.col_en = auto_valid_q;
      sel.row = auto_rc[3:2];
      sel.col = auto_rc[1:0];
    end else begin
      sel = key_sel;
    end
    if (inhibit || !tone_en) begin
      sel.row_en = 1'b0;
      sel.col_en = 1'b0;
    end
  end

  // Status flags from flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      single_key_valid <= 1'b0;
      tone_active_mute <= 1'b0;
    end else begin
      single_key_valid <= single;
      tone_active_mute <= sel.row_en | sel.col_en;
    end
  end

  // Reference tick at 500 kHz
  logic [REF_W-1:0] ref_cnt_q;
  logic ref_tick;
  assign ref_tick = ref_cnt_q == REF_W'(REF_DIV - 1);
  always_ff @(posedge aclk) begin
    if (!aresetn || ref_tick) begin
      ref_cnt_q <= '0;
    end else begin
      ref_cnt_q <= ref_cnt_q + 1'b1;
    end
  end

  // Row and column generators
  ktd_tone u_row (
    .aclk(aclk),
    .aresetn(aresetn),
    .ref_tick(ref_tick),
    .enable(sel.row_en),
    .inc(tone_inc({1'b0, sel.row})),
    .level(row_level)
  );
  ktd_tone u_col (
    .aclk(aclk),
    .aresetn(aresetn),
    .ref_tick(ref_tick),
    .enable(sel.col_en),
    .inc(tone_inc({1'b1, sel.col})),
    .level(col_level)
  );

  // ---------------- AXI4-Lite slave ----------------
  logic aw_got_q, w_got_q;
  logic [3:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic do_write;
  assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
  assign s_axi_wready = !w_got_q && !s_axi_bvalid;
  assign do_write = aw_got_q && w_got_q && !s_axi_bvalid;

  // Hold address and data until both have arrived
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 4'h0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
      end
    end
  end

  // Control register write with byte enables
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= CTRL_RST;
    end else if (do_write && awaddr_q == ADDR_CTRL) begin
      for (int b = 0; b < 4; b++) begin
        if (wstrb_q[b]) ctrl_q[b*8 +: 8] <= wdata_q[b*8 +: 8];
      end
    end
  end

  // Write response; unmapped addresses answer with an error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (awaddr_q == ADDR_CTRL || awaddr_q == ADDR_STATUS || awaddr_q == ADDR_LEVEL)
                     ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      unique case (s_axi_araddr)
        ADDR_CTRL: s_axi_rdata <= ctrl_q;
        ADDR_STATUS: s_axi_rdata <= {22'h0, sel.col_en, sel.row_en, auto_valid_q, auto_mode,
                                     tone_active_mute, single_key_valid, shreg_q};
        ADDR_LEVEL: s_axi_rdata <= {24'h0, col_level, row_level};
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : ktd_dialer

// file: hw/ktd_pkg.sv
// Shared constants, tables and types of the keypad tone dialer port
package ktd_pkg;
  // Clocking and tone synthesis
  localparam int CLK_HZ_DEF = 125_000_000; // Default system clock
  localparam int REF_HZ = 500_000; // Tone reference rate
  localparam int ACC_W = 24; // Phase accumulator width
  localparam int STEP_W = 4; // 16 steps per sine period
  localparam int CLK_PERIOD_NS = 8; // System clock period
  // Clock transition to data valid, longest time
  localparam int T_DV_NS = 10_000;
  localparam int T_DV_CYC = T_DV_NS / CLK_PERIOD_NS; // Rounded down
  localparam int SYNC_LAT_CYC = 4; // Pin to data output latency
  // Serial port sequence
  localparam logic [2:0] CNT_ZERO = 3'h0; // Load phase
  localparam logic [2:0] READ_LAST = 3'h5; // Sixth edge reloads
  localparam logic [2:0] WRITE_BITS = 3'h4; // Bits of one write
  localparam logic [3:0] IDLE_CODE = 4'hf; // Pin rests high
  // Register map, byte addresses
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_LEVEL = 4'h8;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam int CTRL_TONE_EN = 0; // Tone enable bit
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Key code by {row, column}, rows and columns counted from zero
  localparam logic [3:0] KEY_CODE [16] = '{
    4'hf, 4'h7, 4'hb, 4'h3, 4'hd, 4'h5, 4'h9, 4'h1,
    4'he, 4'h6, 4'ha, 4'h2, 4'hc, 4'h4, 4'h8, 4'h0};
  // Tone frequencies in tenths of Hz, rows then columns
  localparam int TONE_DHZ [8] = '{6964, 7692, 8532, 9398, 12077, 13369, 14793, 16340};
  // Sixteen-step sine, midscale 8
  localparam logic [3:0] SINE [16] = '{
    4'h8, 4'hb, 4'hd, 4'he, 4'hf, 4'he, 4'hd, 4'hb,
    4'h8, 4'h5, 4'h3, 4'h2, 4'h1, 4'h2, 4'h3, 4'h5};
  localparam logic [3:0] SINE_MID = 4'h8; // Level while silent

  // Which tones run and at which row and column
  typedef struct packed {
    logic row_en;
    logic col_en;
    logic [1:0] row;
    logic [1:0] col;
  } ktd_tone_sel_t;

  // Phase increment per reference tick for tone index 0..7
  function automatic logic [ACC_W-1:0] tone_inc(input logic [2:0] idx);
    logic [63:0] num;
    num = 64'(TONE_DHZ[idx]) << ACC_W;
    return ACC_W'(num / (64'(REF_HZ) * 64'd10));
  endfunction : tone_inc
endpackage : ktd_pkg

// file: hw/ktd_tone.sv
// Fractional-rate tone generator stepping a 16-step sine
`timescale 1ns/10ps
module ktd_tone
  import ktd_pkg::*;
#(
  parameter int AW = ACC_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ref_tick,
  input wire logic enable,
  input wire logic [AW-1:0] inc,
  output logic [3:0] level
);
  initial begin
    if (AW < STEP_W + 8) $error("ktd_tone: accumulator too narrow");
  end

  logic [AW-1:0] acc_q; // Phase; top four bits are the step
  logic [3:0] level_q; // Converter input

  // Phase accumulator; the fraction carries over so the mean rate is exact
  always_ff @(posedge aclk) begin
    if (!aresetn || !enable) begin
      acc_q <= '0;
    end else if (ref_tick) begin
      acc_q <= acc_q + inc;
    end
  end

  // Step through the sine table
  always_ff @(posedge aclk) begin
    if (!aresetn || !enable) begin
      level_q <= SINE_MID;
    end else begin
      level_q <= SINE[acc_q[AW-1 -: STEP_W]];
    end
  end

  assign level = level_q;
endmodule : ktd_tone

// file: verif/ktd_dialer_chk.sv
// Checker on the dialer ports
`timescale 1ns/10ps
module ktd_dialer_chk
  import ktd_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] row_n,
  input wire logic [3:0] col,
  input wire logic shift_clock,
  input wire logic transfer_direction,
  input wire logic tone_inhibit,
  input wire logic data_o,
  input wire logic data_oe,
  input wire logic single_key_valid,
  input wire logic tone_active_mute,
  input wire logic [3:0] row_level,
  input wire logic [3:0] col_level,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  // Exactly one row and one column closed
  wire one_key = $onehot(~row_n) && $onehot(col);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  oe_manual_a: assert property (!transfer_direction [*6] |-> data_oe)
    else $error("pin not driven in manual mode");
  oe_auto_a: assert property (transfer_direction [*6] |-> !data_oe)
    else $error("pin driven in automatic mode");
  key_valid_a: assert property ((one_key && !transfer_direction) [*6] |-> single_key_valid)
    else $error("single key not flagged");
  key_none_a: assert property ((!one_key) [*6] |-> !single_key_valid)
    else $error("key valid without single key");
  auto_ignore_a: assert property (transfer_direction [*6] |-> !single_key_valid)
    else $error("keypad seen in automatic mode");
  inhibit_a: assert property (tone_inhibit [*6] |-> !tone_active_mute)
    else $error("tone while inhibited");
  tone_on_a: assert property ((one_key && !transfer_direction && !tone_inhibit) [*6] |-> tone_active_mute)
    else $error("key press gave no tone");
  silent_a: assert property ((!tone_active_mute) [*3] |-> row_level == SINE_MID && col_level == SINE_MID)
    else $error("level moves while silent");
  data_hold_a: assert property (
    (shift_clock && !transfer_direction && $stable(row_n) && $stable(col)) [*8] |-> $stable(data_o))
    else $error("data moved without clock fall");
  read_ans_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
endmodule : ktd_dialer_chk

bind ktd_dialer ktd_dialer_chk u_chk (.aclk(aclk), .aresetn(aresetn), .row_n(row_n), .col(col),
  .shift_clock(shift_clock), .transfer_direction(transfer_direction), .tone_inhibit(tone_inhibit),
  .data_o(data_o), .data_oe(data_oe), .single_key_valid(single_key_valid),
  .tone_active_mute(tone_active_mute), .row_level(row_level), .col_level(col_level),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid));

// file: verif/ktd_host_model.sv
// Host processor model driving the serial port
`timescale 1ns/10ps
module ktd_host_model (
  input wire logic aclk,
  input wire logic pin,
  output logic shift_clock,
  output logic transfer_direction,
  output logic tone_inhibit,
  output logic host_d,
  output logic host_oe
);
  // Shift clock rests high between frames
  initial begin
    shift_clock = 1'b1;
    transfer_direction = 1'b0;
    tone_inhibit = 1'b0;
    host_d = 1'b0;
    host_oe = 1'b0;
  end
  // Wait n system clocks
  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask : wt
  // One 125 ns shift clock period, fall first
  task automatic pulse;
    shift_clock <= 1'b0;
    #62.5;
    shift_clock <= 1'b1;
    #62.5;
  endtask : pulse
  // Set the inhibit line
  task automatic set_inhibit(input logic v);
    wt(1);
    tone_inhibit <= v;
  endtask : set_inhibit
  // Six clock read: bit sampled before each of the first four falls, e is pin before fall five
  task automatic read_code(input int w, output logic [3:0] c, output logic e);
    wt(w + 1);
    for (int i = 3; i >= 0; i--) begin
      c[i] = pin;
      pulse();
    end
    e = pin;
    pulse();
    pulse();
  endtask : read_code
  // Automatic mode write of one code, then tones enabled
  task automatic write_code(input logic [3:0] c);
    wt(1);
    tone_inhibit <= 1'b1;
    wt(2500);
    transfer_direction <= 1'b1;
    wt(2500);
    host_oe <= 1'b1;
    for (int i = 3; i >= 0; i--) begin
      host_d <= c[i];
      wt(8);
      pulse();
    end
    host_oe <= 1'b0;
    wt(1250);
    tone_inhibit <= 1'b0;
  endtask : write_code
endmodule : ktd_host_model

// file: verif/tb_ktd_dialer.sv
// Testbench of the dialer host port
`timescale 1ns/10ps
module tb_ktd_dialer;
  import ktd_pkg::*;
  // Codes by {row, column}, first nibble is row 0 column 0
  localparam logic [63:0] KTAB = 64'hf7b3_d591_e6a2_c480;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, row_n = 4'hf, col = 4'h0, wstrb = 4'hf;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic shift_clock, transfer_direction, tone_inhibit, data_o, data_oe, host_d, host_oe;
  logic single_key_valid, tone_active_mute;
  logic [3:0] row_level, col_level;
  int bad_count = 0, tests_run = 0, cyc = 0;
  // Pin level: device, host, else pull-up
  wire pin = data_oe ? data_o : (host_oe ? host_d : 1'b1);
  always #4 aclk = ~aclk;
  ktd_dialer DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .row_n(row_n), .col(col),
    .shift_clock(shift_clock), .transfer_direction(transfer_direction), .tone_inhibit(tone_inhibit),
    .data_i(pin), .data_o(data_o), .data_oe(data_oe), .single_key_valid(single_key_valid),
    .tone_active_mute(tone_active_mute), .row_level(row_level), .col_level(col_level));
  ktd_host_model u_host (.aclk(aclk), .pin(pin), .shift_clock(shift_clock),
    .transfer_direction(transfer_direction), .tone_inhibit(tone_inhibit), .host_d(host_d), .host_oe(host_oe));
  // Verdict and end of run
  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim
  // Compare seen against expected
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Hang guard
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 90000) begin
      bad_count++;
      end_sim();
    end
  end
  // Register write, both items offered together
  task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, tb;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
    end
  endtask : wr
  // Register read
  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
    end
  endtask : rd
  // Keys: rows pulled low, columns driven high
  task automatic keys(input logic [3:0] rn, input logic [3:0] c);
    @(posedge aclk);
    row_n <= rn;
    col <= c;
    repeat (12) @(posedge aclk);
    @(negedge aclk);
  endtask : keys
  // Main sequence
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [3:0] c;
    logic e;
    repeat (20) @(posedge aclk);
    @(negedge aclk);
    chk({data_o, data_oe, single_key_valid, tone_active_mute}, 4'hc);
    chk({row_level, col_level}, 8'h88);
    @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_CTRL, d, r);
    chk({r, d}, {RESP_OKAY, CTRL_RST});
    wr(ADDR_CTRL, 32'h0, r);
    chk(r, RESP_OKAY);
    rd(ADDR_CTRL, d, r);
    chk({r, d}, {RESP_OKAY, 32'h0});
    wr(ADDR_CTRL, CTRL_RST, r);
    wr(4'hc, 32'h1, r);
    chk(r, RESP_SLVERR);
    rd(4'hc, d, r);
    chk({r, d}, {RESP_SLVERR, 32'h0});
    for (int k = 0; k < 16; k++) begin
      keys(~(4'h1 << k[3:2]), 4'h1 << k[1:0]);
      chk(single_key_valid, 1'b1);
      chk(tone_active_mute, 1'b1);
      u_host.read_code(2500, c, e);
      chk(c, KTAB[63 - 4 * k -: 4]);
      chk(e, 1'b1);
      u_host.read_code(0, c, e);
      chk(c, KTAB[63 - 4 * k -: 4]);
      keys(4'hf, 4'h0);
    end
    keys(4'he, 4'h3);
    chk({single_key_valid, tone_active_mute}, 2'b01);
    rd(ADDR_STATUS, d, r);
    chk(d[9:8], 2'b01);
    // Software tone enable off silences the row tone that the two keys ask for
    wr(ADDR_CTRL, 32'h0, r);
    keys(4'he, 4'h3);
    chk({tone_active_mute, row_level}, 5'h08);
    wr(ADDR_CTRL, CTRL_RST, r);
    u_host.set_inhibit(1'b1);
    keys(4'he, 4'h3);
    chk({tone_active_mute, row_level, col_level}, 9'h088);
    keys(4'hf, 4'h0);
    u_host.write_code(4'h3);
    keys(4'hd, 4'h2);
    chk({single_key_valid, tone_active_mute}, 2'b01);
    rd(ADDR_STATUS, d, r);
    chk(d[9:0], 10'h3e3);
    for (int n = 0; n < 6000 && col_level === SINE_MID; n++) @(negedge aclk);
    chk(col_level !== SINE_MID, 1'b1);
    end_sim();
  end
endmodule : tb_ktd_dialer
